// [common/pcmh_pkg.sv]
// constants and types of the pcm highway port
package pcmh_pkg;

  ////////////////////////////////////////////////////////////////////////
  // frame geometry
  localparam int NCH        = 4;
  localparam int SLOT_W     = 7;
  localparam int BIT_W      = 3;
  localparam int SMP_W      = 8;
  localparam int MAX_SLOTS  = 128;
  localparam int CNT_W      = 12;
  localparam int BIDX_W     = 11;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
  localparam logic [BIDX_W-1:0] FRAME_BITS = 11'h400;
  localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
  localparam logic HWY_A = 1'b0;
  localparam logic HWY_B = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // wishbone map, byte addresses
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_SLOT_A = 8'h00;
  localparam logic [ADR_W-1:0] OFS_SLOT_B = 8'h04;
  localparam logic [ADR_W-1:0] OFS_COMMON = 8'h20;
  localparam logic [ADR_W-1:0] OFS_TX_SMP = 8'h40;
  localparam logic [ADR_W-1:0] OFS_RX_SMP = 8'h50;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h60;
  localparam logic [ADR_W-1:0] CFG_STRIDE = 8'h08;
  localparam logic [ADR_W-1:0] SMP_STRIDE = 8'h04;
  localparam int SLOT_REG_W   = 9;
  localparam int COMMON_REG_W = 5;
  localparam int FCNT_W       = 8;

  ////////////////////////////////////////////////////////////////////////
  // register layouts: enable[8] highway[7] slot[6:0]
  typedef struct packed {
    logic              en;
    logic              hwy;
    logic [SLOT_W-1:0] slot;
  } pcmh_slot_t;

  // double rate[4] rising sample[3] delay[2:0]
  typedef struct packed {
    logic             dbl;
    logic             slope;
    logic [BIT_W-1:0] delay;
  } pcmh_common_t;

  // everything handed from the bus side to the link side
  typedef struct packed {
    pcmh_slot_t [NCH-1:0]            tx;
    pcmh_slot_t [NCH-1:0]            rx;
    pcmh_common_t                    com;
    logic       [NCH-1:0][SMP_W-1:0] smp;
  } pcmh_cfg_t;

  // position of one clock period within the frame
  typedef struct packed {
    logic              in_frame;
    logic [SLOT_W-1:0] slot;
    logic [BIT_W-1:0]  bit_n;
    logic              last;
  } pcmh_pos_t;

endpackage

// [src/pcmh_port.sv]
// four channel pcm highway port with wishbone registers
`timescale 1ns/100ps
// Function
// - two highways, each with receive and transmit
// - frame sync starts frame; slot count aligns
// - eight bits per sample, msb first
// - single rate: rise starts, fall samples
// - double rate: two periods, second fall samples
// - rate equals clock, or half in double
// - up to 128 slots of eight bits
// - per channel slot and highway, each direction
// - common delay zero to seven, selectable slope
// - control output low while driving data
// - receive may be strapped to transmit line
module pcmh_port (
  // system clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [pcmh_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // highway clock and frame sync
  input  wire logic                      pcm_clk,
  input  wire logic                      frame_sync,
  // highway a
  input  wire logic                      rx_data_hwy_a,
  output logic                           tx_data_hwy_a,
  output logic                           tx_data_oe_n_hwy_a,
  output logic                           tx_ctrl_n_hwy_a,
  output logic                           tx_ctrl_oe_n_hwy_a,
  // highway b
  input  wire logic                      rx_data_hwy_b,
  output logic                           tx_data_hwy_b,
  output logic                           tx_data_oe_n_hwy_b,
  output logic                           tx_ctrl_n_hwy_b,
  output logic                           tx_ctrl_oe_n_hwy_b
);

  localparam int NCH = pcmh_pkg::NCH;
  localparam int SW  = pcmh_pkg::SMP_W;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  // channel owns the current period on a highway
  function automatic logic chan_hit(input pcmh_pkg::pcmh_slot_t c,
                                    input pcmh_pkg::pcmh_pos_t  p,
                                    input logic                 h);
    return c.en && (c.hwy == h) && p.in_frame && (c.slot == p.slot);
  endfunction

  // frame position of a period count
  function automatic pcmh_pkg::pcmh_pos_t
      calc_pos(input logic [pcmh_pkg::CNT_W-1:0] cnt,
               input pcmh_pkg::pcmh_common_t     com);
    pcmh_pkg::pcmh_pos_t          p;
    logic [pcmh_pkg::CNT_W-1:0]   eff;
    logic [pcmh_pkg::BIDX_W-1:0]  bi;
    eff = cnt - pcmh_pkg::CNT_W'(com.delay);
    bi  = com.dbl ? eff[pcmh_pkg::CNT_W-1:1]
                  : eff[pcmh_pkg::BIDX_W-1:0];
    p.in_frame = (cnt >= pcmh_pkg::CNT_W'(com.delay)) &&
                 (bi < pcmh_pkg::FRAME_BITS);
    p.slot  = bi[pcmh_pkg::BIT_W +: pcmh_pkg::SLOT_W];
    p.bit_n = bi[pcmh_pkg::BIT_W-1:0];
    p.last  = !com.dbl || eff[0];
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus domain state
  pcmh_pkg::pcmh_cfg_t           cfg_q;
  pcmh_pkg::pcmh_cfg_t           xfer_q;
  logic                          pend_q;
  logic                          req_q;
  logic                          ack_q;
  logic [NCH-1:0][SW-1:0]        rx_smp_q;
  logic [pcmh_pkg::FCNT_W-1:0]   fcnt_q;
  logic                          rx_tgl_seen_q;
  logic [1:0]                    bus_sync;
  logic                          busy;
  logic                          wr_go;
  logic                          rd_go;
  logic [31:0]                   rd_val;

  // link domain state
  logic [1:0]                    lnk_sync;
  logic                          lrst_n;
  pcmh_pkg::pcmh_cfg_t           lcfg_q;
  logic                          lack_q;
  logic                          fs_q;
  logic                          fs_rise;
  logic [pcmh_pkg::CNT_W-1:0]    cnt_q;
  logic [pcmh_pkg::CNT_W-1:0]    cnt_d;
  pcmh_pkg::pcmh_pos_t           pos_q;
  pcmh_pkg::pcmh_pos_t           pos_d;
  logic [NCH-1:0][SW-1:0]        tx_cur_q;
  logic [NCH-1:0][SW-1:0]        rx_sr_q;
  logic [NCH-1:0][SW-1:0]        rx_byte_q;
  logic [NCH-1:0][SW-1:0]        rx_hold_q;
  logic                          rx_tgl_q;
  logic [1:0]                    rx_fall_q;
  logic [1:0]                    hit_d;
  logic [1:0]                    dat_d;

  ////////////////////////////////////////////////////////////////////////
  // wishbone handshake, one wait state, unmapped reads return zero
  assign wr_go    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign rd_go    = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (rd_go) begin
        wb_dat_o <= rd_val;
      end
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      if (wb_adr_i == pcmh_pkg::OFS_SLOT_A +
          pcmh_pkg::ADR_W'(c) * pcmh_pkg::CFG_STRIDE) begin
        rd_val[pcmh_pkg::SLOT_REG_W-1:0] = cfg_q.tx[c];
      end
      if (wb_adr_i == pcmh_pkg::OFS_SLOT_B +
          pcmh_pkg::ADR_W'(c) * pcmh_pkg::CFG_STRIDE) begin
        rd_val[pcmh_pkg::SLOT_REG_W-1:0] = cfg_q.rx[c];
      end
      if (wb_adr_i == pcmh_pkg::OFS_TX_SMP +
          pcmh_pkg::ADR_W'(c) * pcmh_pkg::SMP_STRIDE) begin
        rd_val[SW-1:0] = cfg_q.smp[c];
      end
      if (wb_adr_i == pcmh_pkg::OFS_RX_SMP +
          pcmh_pkg::ADR_W'(c) * pcmh_pkg::SMP_STRIDE) begin
        rd_val[SW-1:0] = rx_smp_q[c];
      end
    end
    if (wb_adr_i == pcmh_pkg::OFS_COMMON) begin
      rd_val[pcmh_pkg::COMMON_REG_W-1:0] = cfg_q.com;
    end
    if (wb_adr_i == pcmh_pkg::OFS_STATUS) begin
      rd_val[pcmh_pkg::FCNT_W-1:0] = fcnt_q;
      rd_val[pcmh_pkg::FCNT_W]     = busy || pend_q;
    end
  end

  // configuration and transmit sample registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_q <= '0;
    end else if (wr_go) begin
      for (int c = 0; c < NCH; c++) begin
        if (wb_adr_i == pcmh_pkg::OFS_SLOT_A +
            pcmh_pkg::ADR_W'(c) * pcmh_pkg::CFG_STRIDE) begin
          cfg_q.tx[c] <= wmerge(32'(cfg_q.tx[c]), wb_dat_i,
                         wb_sel_i)[pcmh_pkg::SLOT_REG_W-1:0];
        end
        if (wb_adr_i == pcmh_pkg::OFS_SLOT_B +
            pcmh_pkg::ADR_W'(c) * pcmh_pkg::CFG_STRIDE) begin
          cfg_q.rx[c] <= wmerge(32'(cfg_q.rx[c]), wb_dat_i,
                         wb_sel_i)[pcmh_pkg::SLOT_REG_W-1:0];
        end
        if (wb_adr_i == pcmh_pkg::OFS_TX_SMP +
            pcmh_pkg::ADR_W'(c) * pcmh_pkg::SMP_STRIDE) begin
          cfg_q.smp[c] <= wmerge(32'(cfg_q.smp[c]), wb_dat_i,
                          wb_sel_i)[SW-1:0];
        end
      end
      if (wb_adr_i == pcmh_pkg::OFS_COMMON) begin
        cfg_q.com <= wmerge(32'(cfg_q.com), wb_dat_i,
                     wb_sel_i)[pcmh_pkg::COMMON_REG_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossings
  pcmh_sync #(.W(2)) u_lnk_sync (
    .clk   (pcm_clk),
    .rst_n (1'b1),
    .d     ({reset_n, req_q}),
    .q     (lnk_sync)
  );

  pcmh_sync #(.W(2)) u_bus_sync (
    .clk   (clk),
    .rst_n (reset_n),
    .d     ({rx_tgl_q, lack_q}),
    .q     (bus_sync)
  );

  assign lrst_n = lnk_sync[1];
  assign busy   = req_q != bus_sync[0];

  // pending flag, a write wins over the launch that clears it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (wr_go) begin
      pend_q <= 1'b1;
    end else if (!busy) begin
      pend_q <= 1'b0;
    end
  end

  // toggle handshake: launch a copy while the link is idle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_q  <= 1'b0;
      xfer_q <= '0;
    end else if (pend_q && !busy) begin
      req_q  <= ~req_q;
      xfer_q <= cfg_q;
    end
  end

  // received samples and frame count, on each frame toggle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_tgl_seen_q <= 1'b0;
      rx_smp_q      <= '0;
      fcnt_q        <= '0;
    end else if (bus_sync[1] != rx_tgl_seen_q) begin
      rx_tgl_seen_q <= bus_sync[1];
      rx_smp_q      <= rx_hold_q;
      fcnt_q        <= fcnt_q + pcmh_pkg::FCNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: configuration pick-up
  always_ff @(posedge pcm_clk) begin
    if (!lrst_n) begin
      lack_q <= 1'b0;
      lcfg_q <= '0;
    end else if (lnk_sync[0] != lack_q) begin
      lack_q <= lnk_sync[0];
      lcfg_q <= xfer_q;
    end
  end

  // period counter aligned to the frame sync edge
  assign fs_rise = frame_sync && !fs_q;
  assign cnt_d   = fs_rise ? '0 :
                   (cnt_q == pcmh_pkg::CNT_MAX) ? cnt_q :
                   cnt_q + pcmh_pkg::CNT_W'(1);
  assign pos_d   = calc_pos(cnt_d, lcfg_q.com);

  always_ff @(posedge pcm_clk) begin
    if (!lrst_n) begin
      fs_q  <= 1'b0;
      cnt_q <= pcmh_pkg::CNT_MAX;
      pos_q <= '0;
    end else begin
      fs_q  <= frame_sync;
      cnt_q <= cnt_d;
      pos_q <= pos_d;
    end
  end

  // transmit: drive only in own slots, msb first
  always_comb begin
    hit_d = 2'b00;
    dat_d = 2'b00;
    for (int c = 0; c < NCH; c++) begin
      for (int h = 0; h < 2; h++) begin
        if (chan_hit(lcfg_q.tx[c], pos_d, 1'(h))) begin
          hit_d[h] = 1'b1;
          dat_d[h] = tx_cur_q[c][pcmh_pkg::LAST_BIT - pos_d.bit_n];
        end
      end
    end
  end

  // samples frozen for the whole frame
  always_ff @(posedge pcm_clk) begin
    if (!lrst_n) begin
      tx_cur_q <= '0;
    end else if (fs_rise) begin
      tx_cur_q <= lcfg_q.smp;
    end
  end

  // highway pins change on the rising edge
  assign tx_ctrl_n_hwy_a = 1'b0;
  assign tx_ctrl_n_hwy_b = 1'b0;

  always_ff @(posedge pcm_clk) begin
    if (!lrst_n) begin
      tx_data_hwy_a      <= 1'b0;
      tx_data_hwy_b      <= 1'b0;
      tx_data_oe_n_hwy_a <= 1'b1;
      tx_data_oe_n_hwy_b <= 1'b1;
      tx_ctrl_oe_n_hwy_a <= 1'b1;
      tx_ctrl_oe_n_hwy_b <= 1'b1;
    end else begin
      tx_data_hwy_a      <= dat_d[pcmh_pkg::HWY_A];
      tx_data_hwy_b      <= dat_d[pcmh_pkg::HWY_B];
      tx_data_oe_n_hwy_a <= !hit_d[pcmh_pkg::HWY_A];
      tx_data_oe_n_hwy_b <= !hit_d[pcmh_pkg::HWY_B];
      tx_ctrl_oe_n_hwy_a <= !hit_d[pcmh_pkg::HWY_A];
      tx_ctrl_oe_n_hwy_b <= !hit_d[pcmh_pkg::HWY_B];
    end
  end

  // receive pins caught on the falling edge
  always_ff @(negedge pcm_clk) begin
    rx_fall_q <= {rx_data_hwy_b, rx_data_hwy_a};
  end

  // receive shift at the end of each bit
  always_ff @(posedge pcm_clk) begin
    if (!lrst_n) begin
      rx_sr_q   <= '0;
      rx_byte_q <= '0;
    end else if (pos_q.in_frame && pos_q.last) begin
      for (int c = 0; c < NCH; c++) begin
        for (int h = 0; h < 2; h++) begin
          if (chan_hit(lcfg_q.rx[c], pos_q, 1'(h))) begin
            rx_sr_q[c] <= {rx_sr_q[c][SW-2:0],
                           lcfg_q.com.slope ?
                           (h == 0 ? rx_data_hwy_a : rx_data_hwy_b)
                           : rx_fall_q[h]};
            if (pos_q.bit_n == pcmh_pkg::LAST_BIT) begin
              rx_byte_q[c] <= {rx_sr_q[c][SW-2:0],
                               lcfg_q.com.slope ?
                               (h == 0 ? rx_data_hwy_a : rx_data_hwy_b)
                               : rx_fall_q[h]};
            end
          end
        end
      end
    end
  end

  // hand finished bytes to the bus side once per frame
  always_ff @(posedge pcm_clk) begin
    if (!lrst_n) begin
      rx_hold_q <= '0;
      rx_tgl_q  <= 1'b0;
    end else if (fs_rise) begin
      rx_hold_q <= rx_byte_q;
      rx_tgl_q  <= ~rx_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks, bus domain
  wb_ack_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  wb_ack_timing_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  cfg_launch_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pend_q && !busy && !wr_go) |=> (!pend_q && busy))
    else $error("pending configuration not launched");

  // checks, link domain
  frame_align_a: assert property (@(posedge pcm_clk) disable iff (!lrst_n)
    fs_rise |=> (cnt_q == '0))
    else $error("period count not cleared by frame sync");

  delay_idle_a: assert property (@(posedge pcm_clk) disable iff (!lrst_n)
    (cnt_q < pcmh_pkg::CNT_W'(lcfg_q.com.delay)) |-> !pos_q.in_frame)
    else $error("slot active inside the common delay");

  slot_range_a: assert property (@(posedge pcm_clk) disable iff (!lrst_n)
    pos_q.in_frame |-> (cnt_q < 12'h0808))
    else $error("frame longer than 128 slots");

  dbl_hold_a: assert property (@(posedge pcm_clk) disable iff (!lrst_n)
    (lcfg_q.com.dbl && !pos_q.last && !fs_rise && $stable(lcfg_q))
    |=> (pos_q.last && $stable(pos_q.bit_n)))
    else $error("double rate bit not two periods long");

  single_step_a: assert property (@(posedge pcm_clk) disable iff (!lrst_n)
    (!lcfg_q.com.dbl && pos_q.in_frame && !fs_rise && $stable(lcfg_q))
    |-> pos_q.last)
    else $error("single rate bit spans more than one period");

  ctrl_pairs_a: assert property (@(posedge pcm_clk) disable iff (!lrst_n)
    (tx_ctrl_oe_n_hwy_a == tx_data_oe_n_hwy_a) &&
    (tx_ctrl_oe_n_hwy_b == tx_data_oe_n_hwy_b))
    else $error("control output not matching data drive");

  float_reset_a: assert property (@(posedge pcm_clk)
    !lrst_n |=> (tx_data_oe_n_hwy_a && tx_data_oe_n_hwy_b))
    else $error("highway driven during reset");

  own_hwy_a: assert property (@(posedge pcm_clk) disable iff (!lrst_n)
    !tx_data_oe_n_hwy_a |-> $past(pos_d.in_frame))
    else $error("highway a driven outside the frame");

endmodule

// [src/pcmh_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/100ps
module pcmh_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// [tb/pcmh_far_end.sv]
// far side of the highways: bit clock, frame sync, line model
`timescale 1ns/100ps
module pcmh_far_end #(
  parameter int FP = 96
) (
  // bench settings mirrored here
  input  wire logic          dbl,
  input  wire logic [2:0]    dly,
  input  wire logic [FP-1:0] pat_a,
  input  wire logic [FP-1:0] pat_b,
  // device pins
  input  wire logic          tx_a,
  input  wire logic          oe_n_a,
  input  wire logic          c_oe_n_a,
  input  wire logic          tx_b,
  input  wire logic          oe_n_b,
  input  wire logic          c_oe_n_b,
  // toward the device
  output logic               pcm_clk,
  output logic               frame_sync,
  output logic               rx_a,
  output logic               rx_b,
  // last whole frame: data, driven, control low
  output logic [1:0][FP-1:0] snap_d,
  output logic [1:0][FP-1:0] snap_o,
  output logic [1:0][FP-1:0] snap_c
);
  int                 cnt = 0;
  int                 b;
  logic               own_a;
  logic               own_b;
  logic [1:0][FP-1:0] cur_d;
  logic [1:0][FP-1:0] cur_o;
  logic [1:0][FP-1:0] cur_c;

  //////////////////////////////////////////////////////////////////////////
  // free running bit clock, unrelated phase
  initial begin
    pcm_clk = 1'b0;
    frame_sync = 1'b0;
    #37;
    forever #80 pcm_clk = ~pcm_clk;
  end

  // period count, one period sync pulse, frame snapshot
  always @(posedge pcm_clk) begin
    cnt <= (cnt == FP - 1) ? 0 : cnt + 1;
    frame_sync <= (cnt == FP - 2);
    if (cnt == FP - 1) begin
      snap_d <= cur_d;
      snap_o <= cur_o;
      snap_c <= cur_c;
    end
  end

  // own bits; toggling line before the offset
  assign b = (dbl ? (cnt - int'(dly)) / 2 : cnt - int'(dly));
  assign own_a = (cnt < int'(dly)) ? cnt[0] : pat_a[b];
  assign own_b = (cnt < int'(dly)) ? cnt[0] : pat_b[b];

  // strapped lines: far side keeps off during device slots
  assign rx_a = oe_n_a ? own_a : tx_a;
  assign rx_b = oe_n_b ? own_b : tx_b;

  // mid-bit capture of what the device puts out
  always @(negedge pcm_clk) begin
    cur_d[0][cnt] <= tx_a;
    cur_o[0][cnt] <= ~oe_n_a;
    cur_c[0][cnt] <= ~c_oe_n_a;
    cur_d[1][cnt] <= tx_b;
    cur_o[1][cnt] <= ~oe_n_b;
    cur_c[1][cnt] <= ~c_oe_n_b;
  end
endmodule

// [tb/testbench.sv]
// self-checking bench of the pcm highway port
`timescale 1ns/100ps
module testbench;
  localparam int FP = 96;
  logic               clk, reset_n, cyc, stb, we, ack, dbl, o_a, o_b;
  logic               d_a, d_b, c_a, c_b, pclk, fs, r_a, r_b;
  logic [2:0]         dly;
  logic [7:0]         adr;
  logic [31:0]        dw, dr, q, r, s1;
  logic [FP-1:0]      pat [2];
  logic [7:0]         smp [4];
  logic [1:0][FP-1:0] sd, so, sc;
  logic [1:0]         e;
  int                 err_count = 0;
  int                 n_compared = 0;
  int                 cycles = 0;
  int                 seed = 46;
  int tx_sl[4] = '{0, 2, 1, 3};
  int tx_hw[4] = '{0, 1, 0, 0};
  int tx_en[4] = '{1, 1, 0, 1};
  int rx_sl[4] = '{3, 0, 1, 2};
  int rx_hw[4] = '{1, 0, 0, 1};
  int rx_en[4] = '{1, 0, 1, 1};

  pcmh_port pcmh_port_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .pcm_clk(pclk),
    .frame_sync(fs), .rx_data_hwy_a(r_a), .tx_data_hwy_a(d_a),
    .tx_data_oe_n_hwy_a(o_a), .tx_ctrl_n_hwy_a(), .tx_ctrl_oe_n_hwy_a(c_a),
    .rx_data_hwy_b(r_b), .tx_data_hwy_b(d_b), .tx_data_oe_n_hwy_b(o_b),
    .tx_ctrl_n_hwy_b(), .tx_ctrl_oe_n_hwy_b(c_b));

  pcmh_far_end #(.FP(FP)) pcmh_far_end_i (.dbl(dbl), .dly(dly),
    .pat_a(pat[0]), .pat_b(pat[1]), .tx_a(d_a), .oe_n_a(o_a),
    .c_oe_n_a(c_a), .tx_b(d_b), .oe_n_b(o_b), .c_oe_n_b(c_b),
    .pcm_clk(pclk), .frame_sync(fs), .rx_a(r_a), .rx_b(r_b),
    .snap_d(sd), .snap_o(so), .snap_c(sc));

  //////////////////////////////////////////////////////////////////////////
  // system clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count = err_count + 1;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // classic single wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // expected {driven, value} of highway h in period p
  function automatic logic [1:0] exp_tx(int h, int p);
    logic [1:0] res;
    int         bi;
    int         d;
    res = 2'b00;
    d = dly;
    if (p >= d) begin
      bi = dbl ? (p - d) / 2 : p - d;
      for (int c = 0; c < 4; c++)
        if (tx_en[c] == 1 && tx_hw[c] == h && tx_sl[c] == bi / 8)
          res = {1'b1, smp[c][7 - bi % 8]};
    end
    return res;
  endfunction

  // expected received byte, first bit is msb
  function automatic logic [7:0] exp_rx(int c);
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 8; k++)
      v[7 - k] = pat[rx_hw[c]][rx_sl[c] * 8 + k];
    if (rx_hw[c] == 1 && rx_sl[c] == tx_sl[1])
      v = smp[1];
    return rx_en[c] ? v : 8'h00;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {reset_n, cyc, stb, we, adr, dw, dbl, dly} = '0;
    pat[0] = '0;
    pat[1] = '0;
    repeat (100) @(posedge clk);
    reset_n <= 1'b1;
    wb(1'b0, 8'h04, '0, q);
    chk(q, 32'h0000_0000);
    wb(1'b0, 8'h7c, '0, q);
    chk(q, 32'h0000_0000);
    for (int ps = 0; ps < 2; ps++) begin
      dbl = ps[0];
      r = $random(seed);
      dly = r[2:0];
      pat[0] = {$random(seed), $random(seed), $random(seed)};
      pat[1] = {$random(seed), $random(seed), $random(seed)};
      for (int c = 0; c < 4; c++) begin
        smp[c] = $random(seed);
        wb(1'b1, 8'(8 * c), 32'(tx_en[c] * 256 + tx_hw[c] * 128 + tx_sl[c]), q);
        wb(1'b1, 8'(8 * c + 4), 32'(rx_en[c] * 256 + rx_hw[c] * 128 + rx_sl[c]), q);
        wb(1'b1, 8'(8'h40 + 4 * c), {$random(seed), smp[c]}, q);
      end
      r = $random(seed);
      wb(1'b1, 8'h20, {r[31:5], dbl, dbl, dly}, q);
      wb(1'b0, 8'h20, '0, q);
      chk(q, {27'h000_0000, dbl, dbl, dly});
      do wb(1'b0, 8'h60, '0, q); while (q[8] === 1'b1);
      repeat (3) @(negedge fs);
      repeat (40) @(posedge clk);
      for (int h = 0; h < 2; h++)
        for (int p = 0; p < FP; p++) begin
          e = exp_tx(h, p);
          chk({so[h][p], sd[h][p] & so[h][p], sc[h][p]}, {e[1], &e, e[1]});
        end
      for (int c = 0; c < 4; c++) begin
        wb(1'b0, 8'(8'h50 + 4 * c), '0, q);
        chk(q, {24'h00_0000, exp_rx(c)});
      end
      wb(1'b0, 8'h60, '0, s1);
      @(negedge fs);
      repeat (40) @(posedge clk);
      wb(1'b0, 8'h60, '0, q);
      chk(q[7:0], s1[7:0] + 8'h01);
    end
    summarize();
  end
endmodule
